// ==== hdl/lpm_pkg.sv ====
// constants, state and carrier types of the low-power mode control
package lpm_pkg;

    // ----------------------------------------------------------------
    // clock control word
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       all_clock_stop_bit;
        logic       main_osc_stop_bit;
        logic       wait_peripheral_gate_bit;
        logic       divide_by_eight_flag;
        logic       bus_clk_sub;
        logic [1:0] bus_div;
        logic       vref_connect;
    } lpm_ctrl_t;

    localparam lpm_ctrl_t LPM_CTRL_RST = '{
        all_clock_stop_bit       : 1'b0,
        main_osc_stop_bit        : 1'b0,
        wait_peripheral_gate_bit : 1'b0,
        divide_by_eight_flag     : 1'b1,
        bus_clk_sub              : 1'b0,
        bus_div                  : 2'h0,
        vref_connect             : 1'b0
    };

    // ----------------------------------------------------------------
    // timing and states
    // ----------------------------------------------------------------
    // instructions already in the prefetch queue that may still run
    localparam logic [2:0] LPM_PREFETCH_NOPS = 3'h4;
    localparam logic [2:0] LPM_CNT_ZERO      = 3'h0;
    localparam logic [2:0] LPM_CNT_ONE       = 3'h1;

    typedef enum logic [2:0] {
        LPM_RUN,
        LPM_WAIT_DRAIN,
        LPM_WAIT,
        LPM_STOP_DRAIN,
        LPM_STOP,
        LPM_RESTART
    } lpm_state_t;

endpackage : lpm_pkg

// ==== hdl/lpm_pin_hold.sv ====
// pin state register that freezes while the device is halted
`timescale 1ns/1ns
module lpm_pin_hold #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         hold,
    input  wire logic [W-1:0] d,
    input  wire logic [W-1:0] d_oe,
    output logic      [W-1:0] q,
    output logic      [W-1:0] q_oe
);

    if (W < 1) begin : g_chk
        $error("lpm_pin_hold: width must be at least one");
    end

    // ----------------------------------------------------------------
    // capture while running, keep while halted
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q    <= '0;
            q_oe <= '0;
        end else if (!hold) begin
            q    <= d;
            q_oe <= d_oe;
        end
    end

endmodule : lpm_pin_hold

// ==== hdl/lpm_ctrl.sv ====
// stop and wait mode control with protected clock control bits
//
// Behaviour
// [R1] software enables the wake source and the interrupt flag before stop
// [R2] a protected write of one to the all-clock-stop bit halts oscillation
// [R3] wait instruction enters wait mode after the usual software preparation
// [R4] stop is refused while the non-maskable interrupt pin is low
// [R5] reset exit from stop: reset held low until main oscillator stable
// [R6] up to four prefetched instructions run after wait before halting
// [R7] software puts a short jump before wait, no ram writes or dma between
// [R8] stop write is followed by short jump and four nops; those may run
// [R9] software switches bus clock source only to an oscillator already stable
// [R10] port pins keep their driven state in wait and stop
// [R11] external bus pins hold their state when halted unless single-chip mode
// [R12] software clears the reference connection bit before wait or stop
// [R13] peripheral gate bit stops peripheral clocks in wait, never sub_clock_div32
// [R14] software does not wait with gate bit set in low-speed modes
// [R15] main oscillator stop bit disables the oscillator output, external clock accepted
// [R16] wait exit resumes the same bus clock source and division
// [R17] stop from main clock sets divide-by-eight; from sub clock unchanged
// [R18] enabled wake in stop clears all-clock-stop, interrupt runs once clock stable
// [R19] clock control writes are ignored unless protection was cleared first
`timescale 1ns/1ns
module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int PORT_W = 8,
    parameter int BUS_W  = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              protect_clear,
    input  wire logic              ctrl_wr,
    input  wire lpm_ctrl_t         ctrl_wdata,
    input  wire logic              wait_instr,
    input  wire logic              nmi_n,
    input  wire logic              wake_irq,
    input  wire logic              irq_enable_flag,
    input  wire logic              osc_stable,
    input  wire logic              single_chip_mode,
    input  wire logic [PORT_W-1:0] port_d,
    input  wire logic [PORT_W-1:0] port_d_oe,
    input  wire logic [BUS_W-1:0]  bus_d,
    input  wire logic [BUS_W-1:0]  bus_d_oe,
    output lpm_ctrl_t              ctrl_ff,
    output logic                   prot_open_ff,
    output logic                   cpu_halt_ff,
    output logic                   in_wait_ff,
    output logic                   in_stop_ff,
    output logic                   osc_run_ff,
    output logic                   periph_clk_en_ff,
    output logic                   sub_div32_en_ff,
    output logic                   main_osc_out_en_ff,
    output logic                   irq_seq_start_ff,
    output logic [PORT_W-1:0]      port_q,
    output logic [PORT_W-1:0]      port_q_oe,
    output logic [BUS_W-1:0]       bus_q,
    output logic [BUS_W-1:0]       bus_q_oe
);

    if (PORT_W < 1 || BUS_W < 1) begin : g_chk
        $error("lpm_ctrl: port and bus widths must be at least one");
    end

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    lpm_state_t state_ff;
    lpm_state_t nxt_state;
    logic [2:0] cnt_ff;
    logic       wake_ok;
    logic       drain_done;
    logic       wr_ok;
    logic       nxt_halt;

    assign wake_ok    = wake_irq && irq_enable_flag;
    assign drain_done = (cnt_ff == LPM_PREFETCH_NOPS - LPM_CNT_ONE);
    // writes only land while running; halted software cannot write anyway
    // a pending stop also refuses writes, so the divide-by-eight set cannot be overwritten
    assign wr_ok      = ctrl_wr && prot_open_ff && (state_ff == LPM_RUN) && !ctrl_ff.all_clock_stop_bit;  // [R19] [R16]

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LPM_RUN: begin
                if (ctrl_ff.all_clock_stop_bit) begin
                    nxt_state = LPM_STOP_DRAIN;  // [R2]
                end else if (wait_instr) begin
                    nxt_state = LPM_WAIT_DRAIN;  // [R3]
                end
            end
            LPM_WAIT_DRAIN: begin
                if (drain_done) begin
                    nxt_state = LPM_WAIT;  // [R6]
                end
            end
            LPM_WAIT: begin
                if (wake_ok) begin
                    nxt_state = LPM_RUN;
                end
            end
            LPM_STOP_DRAIN: begin
                if (drain_done) begin
                    nxt_state = LPM_STOP;  // [R8]
                end
            end
            LPM_STOP: begin
                if (wake_ok) begin
                    nxt_state = LPM_RESTART;  // [R18]
                end
            end
            LPM_RESTART: begin
                if (osc_stable) begin
                    nxt_state = LPM_RUN;  // [R18]
                end
            end
            default: nxt_state = LPM_RUN;
        endcase
    end

    assign nxt_halt = (nxt_state == LPM_WAIT) || (nxt_state == LPM_STOP) || (nxt_state == LPM_RESTART);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= LPM_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // the drain counter models the prefetch queue emptying before halt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= LPM_CNT_ZERO;
        end else if (nxt_state == LPM_WAIT_DRAIN || nxt_state == LPM_STOP_DRAIN) begin
            cnt_ff <= (state_ff == nxt_state) ? cnt_ff + LPM_CNT_ONE : LPM_CNT_ZERO;  // [R6] [R8]
        end else begin
            cnt_ff <= LPM_CNT_ZERO;
        end
    end

    // ----------------------------------------------------------------
    // write protection
    // ----------------------------------------------------------------
    // one clear opens exactly one write, so a stray store cannot slip in
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prot_open_ff <= 1'b0;
        end else if (protect_clear) begin
            prot_open_ff <= 1'b1;
        end else if (ctrl_wr) begin
            prot_open_ff <= 1'b0;  // [R19]
        end
    end

    // ----------------------------------------------------------------
    // clock control bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= LPM_CTRL_RST;
        end else if (wr_ok) begin
            ctrl_ff                    <= ctrl_wdata;
            ctrl_ff.all_clock_stop_bit <= ctrl_wdata.all_clock_stop_bit && nmi_n;  // [R4]
        end else if (state_ff == LPM_RUN && ctrl_ff.all_clock_stop_bit) begin
            if (!ctrl_ff.bus_clk_sub) begin
                ctrl_ff.divide_by_eight_flag <= 1'b1;  // [R17]
            end
        end else if (state_ff == LPM_STOP && wake_ok) begin
            ctrl_ff.all_clock_stop_bit <= 1'b0;  // [R18]
        end
    end

    // ----------------------------------------------------------------
    // clock enables and mode status
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_halt_ff        <= 1'b0;
            in_wait_ff         <= 1'b0;
            in_stop_ff         <= 1'b0;
            osc_run_ff         <= 1'b1;
            periph_clk_en_ff   <= 1'b1;
            sub_div32_en_ff    <= 1'b1;
            main_osc_out_en_ff <= 1'b1;
        end else begin
            cpu_halt_ff        <= nxt_halt;
            in_wait_ff         <= (nxt_state == LPM_WAIT);
            in_stop_ff         <= (nxt_state == LPM_STOP);
            osc_run_ff         <= (nxt_state != LPM_STOP);  // [R2]
            periph_clk_en_ff   <= !((nxt_state == LPM_WAIT) && ctrl_ff.wait_peripheral_gate_bit)
                                  && (nxt_state != LPM_STOP);  // [R13]
            sub_div32_en_ff    <= (nxt_state != LPM_STOP);  // [R13]
            // an external clock on main_osc_input is taken whatever this says
            main_osc_out_en_ff <= !ctrl_ff.main_osc_stop_bit && (nxt_state != LPM_STOP);  // [R15]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_seq_start_ff <= 1'b0;
        end else begin
            irq_seq_start_ff <= (state_ff == LPM_RESTART && osc_stable)
                                || (state_ff == LPM_WAIT && wake_ok);  // [R18]
        end
    end

    // ----------------------------------------------------------------
    // pin state retention
    // ----------------------------------------------------------------
    lpm_pin_hold #(
        .W (PORT_W)
    ) u_port_hold (
        .clk   (clk),
        .rst_n (rst_n),
        .hold  (nxt_halt),  // [R10]
        .d     (port_d),
        .d_oe  (port_d_oe),
        .q     (port_q),
        .q_oe  (port_q_oe)
    );

    lpm_pin_hold #(
        .W (BUS_W)
    ) u_bus_hold (
        .clk   (clk),
        .rst_n (rst_n),
        .hold  (nxt_halt && !single_chip_mode),  // [R11]
        .d     (bus_d),
        .d_oe  (bus_d_oe),
        .q     (bus_q),
        .q_oe  (bus_q_oe)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_protect_gate: assert property (@(posedge clk) disable iff (!rst_n)  // [R19]
        ctrl_wr && !prot_open_ff && !ctrl_ff.all_clock_stop_bit && state_ff == LPM_RUN
        |=> $stable(ctrl_ff)) else $error("protected write changed control");

    a_nmi_blocks_stop: assert property (@(posedge clk) disable iff (!rst_n)  // [R4]
        ctrl_wr && !nmi_n && !ctrl_ff.all_clock_stop_bit
        |=> !ctrl_ff.all_clock_stop_bit ##1 state_ff != LPM_STOP_DRAIN) else $error("stop taken with nmi low");

    a_wait_drain: assert property (@(posedge clk) disable iff (!rst_n)  // [R6]
        state_ff == LPM_RUN && wait_instr && !ctrl_ff.all_clock_stop_bit
        |=> !cpu_halt_ff [*4] ##1 (cpu_halt_ff && in_wait_ff)) else $error("wait halt timing wrong");

    a_stop_entry: assert property (@(posedge clk) disable iff (!rst_n)  // [R2]
        $rose(ctrl_ff.all_clock_stop_bit) && state_ff == LPM_RUN
        |-> ##[1:6] (in_stop_ff && !osc_run_ff && !main_osc_out_en_ff)) else $error("stop not reached");

    a_div8_on_stop: assert property (@(posedge clk) disable iff (!rst_n)  // [R17]
        state_ff == LPM_RUN && ctrl_ff.all_clock_stop_bit && !ctrl_ff.bus_clk_sub
        |=> ctrl_ff.divide_by_eight_flag) else $error("divide-by-eight not set");

    a_wake_clears: assert property (@(posedge clk) disable iff (!rst_n)  // [R18]
        state_ff == LPM_STOP && wake_irq && irq_enable_flag
        |=> !ctrl_ff.all_clock_stop_bit && state_ff == LPM_RESTART) else $error("wake did not clear stop");

    a_irq_after_osc: assert property (@(posedge clk) disable iff (!rst_n)  // [R18]
        state_ff == LPM_RESTART |=> irq_seq_start_ff == $past(osc_stable)) else $error("interrupt start misplaced");

    a_periph_gate: assert property (@(posedge clk) disable iff (!rst_n)  // [R13]
        in_wait_ff |-> (sub_div32_en_ff && periph_clk_en_ff == !ctrl_ff.wait_peripheral_gate_bit))
        else $error("peripheral gating wrong in wait");

    a_port_hold: assert property (@(posedge clk) disable iff (!rst_n)  // [R10]
        cpu_halt_ff && $past(cpu_halt_ff) |-> $stable(port_q) && $stable(port_q_oe)) else $error("port moved while halted");

    a_bus_hold: assert property (@(posedge clk) disable iff (!rst_n)  // [R11]
        cpu_halt_ff && $past(cpu_halt_ff) && !single_chip_mode && !$past(single_chip_mode)
        |-> $stable(bus_q)) else $error("bus pins moved while halted");

    a_wait_keeps_clk: assert property (@(posedge clk) disable iff (!rst_n)  // [R16]
        state_ff == LPM_WAIT |=> $stable(ctrl_ff.bus_clk_sub) && $stable(ctrl_ff.bus_div))
        else $error("bus clock changed across wait");

endmodule : lpm_ctrl

// ==== dv/lpm_ctrl_test.sv ====
// self-checking bench for the low-power mode control
`timescale 1ns/1ns
module lpm_ctrl_test
    import lpm_pkg::*;
;
    logic       clk, rst_n, protect_clear, ctrl_wr, wait_instr, nmi_n, wake_irq;
    logic       irq_enable_flag, osc_stable, single_chip_mode;
    lpm_ctrl_t  ctrl_wdata, ctrl_ff;
    logic [7:0] port_d, port_d_oe, bus_d, bus_d_oe, port_q, port_q_oe, bus_q, bus_q_oe;
    logic       prot_open_ff, cpu_halt_ff, in_wait_ff, in_stop_ff, osc_run_ff;
    logic       periph_clk_en_ff, sub_div32_en_ff, main_osc_out_en_ff, irq_seq_start_ff;
    int         n_fail = 0;
    int         cmp_count = 0;
    // ----------------------------------------------------------------
    // ordinary control writes: protection flag, data, expected word
    // ----------------------------------------------------------------
    logic       row_prot [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [7:0] row_wd   [5] = '{8'h0F, 8'h07, 8'h4A, 8'h00, 8'h02};
    logic [7:0] row_exp  [5] = '{8'h10, 8'h07, 8'h4A, 8'h4A, 8'h02};

    lpm_ctrl #(.PORT_W(8), .BUS_W(8)) dut (
        .clk(clk), .rst_n(rst_n), .protect_clear(protect_clear), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .wait_instr(wait_instr), .nmi_n(nmi_n), .wake_irq(wake_irq),
        .irq_enable_flag(irq_enable_flag), .osc_stable(osc_stable), .single_chip_mode(single_chip_mode),
        .port_d(port_d), .port_d_oe(port_d_oe), .bus_d(bus_d), .bus_d_oe(bus_d_oe),
        .ctrl_ff(ctrl_ff), .prot_open_ff(prot_open_ff), .cpu_halt_ff(cpu_halt_ff),
        .in_wait_ff(in_wait_ff), .in_stop_ff(in_stop_ff), .osc_run_ff(osc_run_ff),
        .periph_clk_en_ff(periph_clk_en_ff), .sub_div32_en_ff(sub_div32_en_ff),
        .main_osc_out_en_ff(main_osc_out_en_ff), .irq_seq_start_ff(irq_seq_start_ff),
        .port_q(port_q), .port_q_oe(port_q_oe), .bus_q(bus_q), .bus_q_oe(bus_q_oe)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // optional protection pulse, then one write; returns at the edge that takes it
    task automatic wr(input logic prot, input logic [7:0] w);
        @(posedge clk) protect_clear <= prot;
        @(posedge clk) begin
            protect_clear <= 1'b0;
            ctrl_wr       <= 1'b1;
            ctrl_wdata    <= w;
        end
        @(posedge clk) ctrl_wr <= 1'b0;
    endtask : wr

    task automatic pins(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk) begin
            port_d    <= a;
            port_d_oe <= ~a;
            bus_d     <= b;
            bus_d_oe  <= ~b;
        end
    endtask : pins

    // pulse an input for one cycle; the closing edge is the one that takes it
    task automatic wake();
        @(posedge clk) wake_irq <= 1'b1;
        @(posedge clk) wake_irq <= 1'b0;
        @(negedge clk);
    endtask : wake

    initial begin
        #(40 * 3000);
        n_fail++;
        print_verdict();
    end

    initial begin
        {rst_n, protect_clear, ctrl_wr, wait_instr, wake_irq, osc_stable, single_chip_mode} = '0;
        {nmi_n, irq_enable_flag} = 2'b11;
        ctrl_wdata = LPM_CTRL_RST;
        {port_d, port_d_oe, bus_d, bus_d_oe} = '0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk(ctrl_ff, LPM_CTRL_RST);
        chk({3'h0, osc_run_ff, periph_clk_en_ff, sub_div32_en_ff, main_osc_out_en_ff, cpu_halt_ff}, 8'h1E);
        @(posedge clk) rst_n <= 1'b1;
        // ------------------------------------------------------------
        // table of protected and unprotected writes
        // ------------------------------------------------------------
        for (int i = 0; i < 5; i++) begin
            wr(row_prot[i], row_wd[i]);
            @(negedge clk);
            chk(ctrl_ff, row_exp[i]);
            chk({7'h00, prot_open_ff}, 8'h00);
            // the oscillator enable follows the control word one cycle later
            @(negedge clk);
            chk({7'h00, main_osc_out_en_ff}, {7'h00, ~row_exp[i][6]});
        end
        // ------------------------------------------------------------
        // wait with peripheral gate: drain, freeze, wake
        // ------------------------------------------------------------
        wr(1'b1, 8'h22);
        pins(8'hA5, 8'h3C);
        @(posedge clk) wait_instr <= 1'b1;
        @(posedge clk) wait_instr <= 1'b0;
        repeat (4) begin
            @(negedge clk);
            chk({7'h00, cpu_halt_ff}, 8'h00);
        end
        @(negedge clk);
        chk({4'h0, cpu_halt_ff, in_wait_ff, periph_clk_en_ff, sub_div32_en_ff}, 8'h0D);
        pins(8'h5A, 8'hC3);
        repeat (2) @(negedge clk);
        chk(port_q, 8'hA5);
        chk(port_q_oe, 8'h5A);
        chk(bus_q, 8'h3C);
        chk(bus_q_oe, 8'hC3);
        wake();
        chk({5'h00, cpu_halt_ff, in_wait_ff, irq_seq_start_ff}, 8'h01);
        chk(ctrl_ff, 8'h22);
        @(negedge clk);
        chk({6'h00, irq_seq_start_ff, periph_clk_en_ff}, 8'h01);
        repeat (2) @(negedge clk);
        chk(port_q, 8'h5A);
        // ------------------------------------------------------------
        // stop refused while the nmi pin is low
        // ------------------------------------------------------------
        @(posedge clk) nmi_n <= 1'b0;
        wr(1'b1, 8'h82);
        repeat (8) @(negedge clk);
        chk({4'h0, ctrl_ff[7], in_stop_ff, cpu_halt_ff, osc_run_ff}, 8'h01);
        chk(ctrl_ff, 8'h02);
        @(posedge clk) nmi_n <= 1'b1;
        // ------------------------------------------------------------
        // stop from main clock, wake, restart on stable oscillator
        // ------------------------------------------------------------
        wr(1'b1, 8'h82);
        repeat (5) begin
            @(negedge clk);
            chk({7'h00, in_stop_ff}, 8'h00);
        end
        @(negedge clk);
        chk({3'h0, in_stop_ff, cpu_halt_ff, osc_run_ff, sub_div32_en_ff, main_osc_out_en_ff}, 8'h18);
        chk(ctrl_ff, 8'h92);
        pins(8'h11, 8'h22);
        @(posedge clk) single_chip_mode <= 1'b1;
        repeat (3) @(negedge clk);
        chk(bus_q, 8'h22);
        chk(port_q, 8'h5A);
        wake();
        chk({3'h0, ctrl_ff[7], in_stop_ff, osc_run_ff, cpu_halt_ff, irq_seq_start_ff}, 8'h06);
        chk(ctrl_ff, 8'h12);
        repeat (3) @(negedge clk);
        chk({7'h00, cpu_halt_ff}, 8'h01);
        @(posedge clk) osc_stable <= 1'b1;
        @(posedge clk) osc_stable <= 1'b0;
        @(negedge clk);
        chk({6'h00, cpu_halt_ff, irq_seq_start_ff}, 8'h01);
        // ------------------------------------------------------------
        // stop from sub clock; wake needs the interrupt flag
        // ------------------------------------------------------------
        @(posedge clk) irq_enable_flag <= 1'b0;
        wr(1'b1, 8'h8A);
        repeat (7) @(negedge clk);
        chk(ctrl_ff, 8'h8A);
        wake();
        repeat (2) @(negedge clk);
        chk({7'h00, in_stop_ff}, 8'h01);
        @(posedge clk) irq_enable_flag <= 1'b1;
        wake();
        chk({6'h00, ctrl_ff[7], in_stop_ff}, 8'h00);
        chk(ctrl_ff, 8'h0A);
        @(posedge clk) osc_stable <= 1'b1;
        @(posedge clk) osc_stable <= 1'b0;
        @(negedge clk);
        chk({6'h00, cpu_halt_ff, irq_seq_start_ff}, 8'h01);
        // ------------------------------------------------------------
        // reset in mid-run while halted in wait
        // ------------------------------------------------------------
        @(posedge clk) wait_instr <= 1'b1;
        @(posedge clk) wait_instr <= 1'b0;
        repeat (6) @(negedge clk);
        chk({6'h00, cpu_halt_ff, in_wait_ff}, 8'h03);
        @(posedge clk) rst_n <= 1'b0;
        #1;
        chk(ctrl_ff, LPM_CTRL_RST);
        chk({6'h00, cpu_halt_ff, in_wait_ff}, 8'h00);
        chk(port_q, 8'h00);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h00, cpu_halt_ff}, 8'h00);
        print_verdict();
    end
endmodule : lpm_ctrl_test
